// file: rtl/lsm_meas_ctrl.sv
// Overview of operation
// R1: Each modulator-off bit, when one, disables its own modulator.
// R2: Enable bit 6 starts or stops flicker detection as written.
// R3: Enable bit 1 switches ambient light measurement on or off.
// R4: Setting the power bit starts the internal oscillator.
// R5: Clearing the power bit stops oscillator and clears both sense enables.
// R6: Host should set power only after configuring everything else.
// R7: Stop-after-count clears both sense enables after n runs, power stays.
// R8: Double drop bit makes saturation lower gain two steps above zero.
// R9: Single-shot bit runs one sequencer cycle then raises sleep-after-irq.
// R10: Ambient status bit writes ambient status words into the queue.
// R11: Scale field counts leading zeros needed to use the scaled result.
// R12: Ambient result up to 26 bits; 5-bit field selects its top bit.
// R13: End marker bit appends end marker after each flicker measurement.
// R14: Checksum bit appends flicker checksum after each flicker measurement.
// R15: Gain bit appends gain value after each flicker measurement.
// R16: Endless repeat mode writes no end markers and keeps streaming.
// R17: Reserved bits read zero, ignore writes; reset sets listed values.
// R18: Trailer items leave in order gain, checksum, end marker.
//
// Purpose: Measurement control register bank of a light sensor.
// Assumes: Avalon-MM slave, word address = register index, 32-bit data.
// Notes:   Measurement engine events arrive as same-clock pulses.
//
// Added by the designer: the Avalon-MM interface to the registers.
`include "lsm_map.svh"

module lsm_meas_ctrl #(
    parameter int RES_W = 32
) (
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rst,
    input  wire logic [7:0]             i_avs_address,
    input  wire logic                   i_avs_read,
    input  wire logic                   i_avs_write,
    input  wire logic [31:0]            i_avs_writedata,
    input  wire logic [3:0]             i_avs_byteenable,
    output logic      [31:0]            o_avs_readdata,
    output logic                        o_avs_waitrequest,
    input  wire logic                   i_meas_done,
    input  wire logic                   i_flicker_done,
    input  wire logic                   i_seq_cycle_done,
    input  wire logic                   i_analog_sat,
    input  wire logic [3:0]             i_gain_step,
    input  wire logic                   i_flicker_endless_repeat,
    input  wire logic [RES_W-1:0]       i_amb_result,
    output logic      [2:0]             o_modulator_off,
    output logic                        o_osc_run,
    output logic                        o_flicker_run,
    output logic                        o_ambient_run,
    output logic                        o_sleep_after_irq,
    output logic      [1:0]             o_gain_drop,
    output logic                        o_ambient_status_to_queue,
    output logic                        o_trailer_valid,
    output lsm_pkg::lsm_trailer_e       o_trailer_item,
    output logic      [15:0]            o_amb_data,
    output logic                        o_amb_scaled
);
    import lsm_pkg::*;

    // The masking and read mux assume a 32-bit result word.
    if (RES_W != 32) begin : g_res_w_check
        $error("RES_W must be 32");
    end

    // Control registers.
    lsm_byte_t mod_off;
    lsm_byte_t enables;
    lsm_byte_t mode_low;
    lsm_byte_t mode_high;
    lsm_byte_t stop_count;
    lsm_byte_t runs_left;
    logic      ack;

    lsm_trl_if trl ();

    // Register decode and write strobe; only byte lane 0 carries data.
    wire logic       hit_mod   = (i_avs_address == `LSM_IDX_MOD_OFF);
    wire logic       hit_en    = (i_avs_address == `LSM_IDX_ENABLE);
    wire logic       hit_low   = (i_avs_address == `LSM_IDX_MODE_LOW);
    wire logic       hit_high  = (i_avs_address == `LSM_IDX_MODE_HIGH);
    wire logic       hit_evt   = (i_avs_address == `LSM_IDX_EVENTS);
    wire logic       hit_res   = (i_avs_address == `LSM_IDX_RESULT);
    wire logic       hit_cnt   = (i_avs_address == `LSM_IDX_STOP_COUNT);
    wire logic       wr_take   = i_avs_write & ~ack & i_avs_byteenable[0];
    wire lsm_byte_t  wdata     = i_avs_writedata[7:0];

    // Writing power to zero forces both sense enables low.
    wire lsm_byte_t  en_written = wdata[`LSM_BIT_ON]
                     ? (wdata & `LSM_MASK_ENABLE)
                     : 8'h00; // see R5 see R17

    // Stop condition for stop-after-count on a completed measurement.
    wire logic stop_hit = mode_low[`LSM_BIT_STOPCNT] & i_meas_done
                        & (runs_left <= 8'h01); // see R7

    // Sense enables are dropped when the count runs out; power stays.
    wire lsm_byte_t next_enables = (wr_take & hit_en) ? en_written
        : stop_hit ? (enables & ~(8'h01 << `LSM_BIT_FLK)
                              & ~(8'h01 << `LSM_BIT_AMB))
        : enables; // see R7 see R2 see R3

    // Iteration counter reloads whenever enables are written.
    wire lsm_byte_t next_runs_left = (wr_take & hit_en) ? stop_count
        : (mode_low[`LSM_BIT_STOPCNT] & i_meas_done & runs_left != 8'h00)
          ? runs_left - 8'h01
        : runs_left; // see R7

    // Single wait cycle: every access answers after one waitrequest cycle.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ack <= 1'b0;
        end else begin
            ack <= (i_avs_read | i_avs_write) & ~ack;
        end
    end

    // Configuration registers; reserved bits never store.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            mod_off    <= `LSM_RST_MOD_OFF;
            mode_low   <= `LSM_RST_MODE_LOW;
            mode_high  <= `LSM_RST_MODE_HIGH;
            stop_count <= `LSM_RST_STOP_COUNT; // see R17
        end else if (wr_take) begin
            if (hit_mod) begin
                mod_off <= wdata & `LSM_MASK_MOD_OFF; // see R17
            end
            if (hit_low) begin
                mode_low <= wdata;
            end
            if (hit_high) begin
                mode_high <= wdata;
            end
            if (hit_cnt) begin
                stop_count <= wdata;
            end
        end
    end

    // Enables and iteration count update together.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            enables   <= `LSM_RST_ENABLE;
            runs_left <= `LSM_RST_STOP_COUNT;
        end else begin
            enables   <= next_enables;
            runs_left <= next_runs_left;
        end
    end

    // Trailer request after each finished flicker measurement.
    assign trl.start   = i_flicker_done & ~trl.busy;
    assign trl.gain_en = mode_high[`LSM_BIT_GAIN]; // see R15
    assign trl.sum_en  = mode_high[`LSM_BIT_CHKSUM]; // see R14
    // Endless repeat never terminates, so no end marker is written.
    assign trl.end_en  = mode_high[`LSM_BIT_ENDMARK]
                       & ~i_flicker_endless_repeat; // see R13 see R16

    lsm_trailer_seq u_trailer (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .trl        (trl)
    );

    logic [15:0] amb_data;
    logic        amb_scaled;

    lsm_amb_scale #(
        .RES_W (RES_W)
    ) u_scale (
        .i_result     (i_amb_result),
        .i_top_bit    (mode_high[4:0]),
        .i_zero_count (mode_low[3:0]),
        .o_data       (amb_data),
        .o_scaled     (amb_scaled)
    );

    // Gain drop: two steps only when enabled and the step can take it.
    wire logic [1:0] drop_now = !i_analog_sat ? 2'h0
        : (mode_low[`LSM_BIT_DBLDROP] && i_gain_step > 4'h0) ? 2'h2
        : 2'h1; // see R8

    // Sleep after interrupt is raised once the single cycle completes.
    wire logic sai_set = mode_low[`LSM_BIT_ONESHOT] & i_seq_cycle_done;

    // Read mux; unmapped addresses read zero.
    wire logic [31:0] rd_mux =
          hit_mod  ? {24'h000000, mod_off}
        : hit_en   ? {24'h000000, enables}
        : hit_low  ? {24'h000000, mode_low}
        : hit_high ? {24'h000000, mode_high}
        : hit_cnt  ? {24'h000000, stop_count}
        : hit_evt  ? {24'h000000, runs_left[6:0], o_sleep_after_irq}
        : hit_res  ? {15'h0000, o_amb_scaled, o_amb_data}
        : 32'h00000000;

    // Outputs are all registered; power gates every run level.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_avs_readdata            <= 32'h00000000;
            o_modulator_off           <= 3'h0;
            o_osc_run                 <= 1'b0;
            o_flicker_run             <= 1'b0;
            o_ambient_run             <= 1'b0;
            o_gain_drop               <= 2'h0;
            o_ambient_status_to_queue <= 1'b0;
            o_trailer_valid           <= 1'b0;
            o_trailer_item            <= LSM_TRL_GAIN;
            o_amb_data                <= 16'h0000;
            o_amb_scaled              <= 1'b0;
        end else begin
            o_avs_readdata            <= rd_mux;
            o_modulator_off           <= mod_off[2:0]; // see R1
            o_osc_run                 <= next_enables[`LSM_BIT_ON]; // see R4
            o_flicker_run             <= next_enables[`LSM_BIT_FLK]; // see R2
            o_ambient_run             <= next_enables[`LSM_BIT_AMB]; // see R3
            o_gain_drop               <= drop_now; // see R8
            o_ambient_status_to_queue <= mode_low[`LSM_BIT_AMBSTAT]; // see R10
            o_trailer_valid           <= trl.item_valid;
            o_trailer_item            <= trl.item; // see R18
            o_amb_data                <= amb_data; // see R11
            o_amb_scaled              <= amb_scaled; // see R12
        end
    end

    // Sleep flag: set wins over a clear by power-down write.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sleep_after_irq <= 1'b0;
        end else if (sai_set) begin
            o_sleep_after_irq <= 1'b1; // see R9
        end else if (wr_take & hit_en & ~wdata[`LSM_BIT_ON]) begin
            o_sleep_after_irq <= 1'b0;
        end
    end

    // Waitrequest is high until the answer cycle.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & ~ack);
        end
    end
endmodule

// file: rtl/lsm_map.svh
// Purpose: Register offsets, field positions and reset values.
// Assumes: Byte offsets index 32-bit words; byte address is four times.
// Notes:   Definitions only.
`ifndef LSM_MAP_SVH
`define LSM_MAP_SVH
`define LSM_IDX_MOD_OFF      8'h40
`define LSM_IDX_ENABLE       8'h80
`define LSM_IDX_MODE_LOW     8'h81
`define LSM_IDX_MODE_HIGH    8'h82
`define LSM_IDX_EVENTS       8'h90
`define LSM_IDX_RESULT       8'h91
`define LSM_IDX_STOP_COUNT   8'h92
`define LSM_BIT_ON           0
`define LSM_BIT_AMB          1
`define LSM_BIT_FLK          6
`define LSM_BIT_STOPCNT      7
`define LSM_BIT_DBLDROP      6
`define LSM_BIT_ONESHOT      5
`define LSM_BIT_AMBSTAT      4
`define LSM_BIT_ENDMARK      7
`define LSM_BIT_CHKSUM       6
`define LSM_BIT_GAIN         5
`define LSM_MASK_MOD_OFF     8'h07
`define LSM_MASK_ENABLE      8'h43
`define LSM_RST_MOD_OFF      8'h00
`define LSM_RST_ENABLE       8'h00
`define LSM_RST_MODE_LOW     8'h04
`define LSM_RST_MODE_HIGH    8'h0C
`define LSM_RST_STOP_COUNT   8'h01
`define LSM_AMB_RAW_BITS     26
`define LSM_ACK_WAIT         1
`endif

// file: rtl/lsm_pkg.sv
// Purpose: Types shared by the light sensor control files.
// Assumes: Nothing beyond the map header.
// Notes:   Trailer items leave in the listed enum order.
package lsm_pkg;
    typedef enum logic [1:0] {
        LSM_TRL_GAIN,
        LSM_TRL_CHECKSUM,
        LSM_TRL_END
    } lsm_trailer_e;
    typedef logic [7:0] lsm_byte_t;
endpackage

// file: rtl/lsm_trl_if.sv
// Purpose: Carries trailer requests from the control core to the sequencer.
// Assumes: One clock; all signals are levels or one-cycle pulses.
// Notes:   Source modport drives, sink modport answers.
interface lsm_trl_if;
    logic               start;
    logic               gain_en;
    logic               sum_en;
    logic               end_en;
    logic               busy;
    logic               item_valid;
    lsm_pkg::lsm_trailer_e item;
    modport source (output start, output gain_en, output sum_en,
                    output end_en, input busy, input item_valid,
                    input item);
    modport sink   (input start, input gain_en, input sum_en,
                    input end_en, output busy, output item_valid,
                    output item);
endinterface

// file: rtl/lsm_trailer_seq.sv
// Purpose: Emits the enabled trailer items after a flicker measurement.
// Assumes: start is a one-cycle pulse; enables stay steady while busy.
// Notes:   One item per cycle, gain first, end marker last.
module lsm_trailer_seq (
    input  wire logic   i_core_clk,
    input  wire logic   i_rst,
    lsm_trl_if.sink     trl
);
    import lsm_pkg::*;

    typedef enum logic [1:0] {
        LSM_ST_IDLE,
        LSM_ST_GAIN,
        LSM_ST_SUM,
        LSM_ST_END
    } lsm_seq_e;

    lsm_seq_e state;
    lsm_seq_e next_state;

    // Every step is visited; a disabled item simply raises no valid.
    always_comb begin
        next_state = state;
        case (state)
            LSM_ST_IDLE: next_state = trl.start ? LSM_ST_GAIN : LSM_ST_IDLE;
            LSM_ST_GAIN: next_state = LSM_ST_SUM;
            LSM_ST_SUM:  next_state = LSM_ST_END;
            LSM_ST_END:  next_state = LSM_ST_IDLE;
            default:     next_state = LSM_ST_IDLE;
        endcase
    end

    // Registered state; outputs decode from it.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= LSM_ST_IDLE;
        end else begin
            state <= next_state; // see R18
        end
    end

    // Fixed order gain, checksum, end marker.
    assign trl.busy       = (state != LSM_ST_IDLE);
    assign trl.item_valid = (state == LSM_ST_GAIN && trl.gain_en)
                          | (state == LSM_ST_SUM  && trl.sum_en)
                          | (state == LSM_ST_END  && trl.end_en); // see R18
    assign trl.item       = (state == LSM_ST_GAIN) ? LSM_TRL_GAIN
                          : (state == LSM_ST_SUM)  ? LSM_TRL_CHECKSUM
                          : LSM_TRL_END;
endmodule

// file: rtl/lsm_amb_scale.sv
// Purpose: Picks scaled or unscaled ambient result for the 16-bit output.
// Assumes: Result word is 32 bits; top bit index comes from software.
// Notes:   Purely combinational; the top module registers the output.
module lsm_amb_scale #(
    parameter int RES_W = 32
) (
    input  wire logic [RES_W-1:0] i_result,
    input  wire logic [4:0]       i_top_bit,
    input  wire logic [3:0]       i_zero_count,
    output logic      [15:0]      o_data,
    output logic                  o_scaled
);
    logic [RES_W-1:0] masked;
    logic [RES_W-1:0] top_window;
    logic [RES_W-1:0] aligned;
    logic [4:0]       shift;

    // Bits above the selected top position are not part of the result.
    assign masked = i_result & ((({{(RES_W-1){1'b0}}, 1'b1}
                    << (i_top_bit + 6'h01)) - 1'b1)); // see R12
    // The window of leading bits that must be zero to allow scaling.
    assign top_window = masked >> (i_top_bit + 6'h01 - {2'h0, i_zero_count});
    assign o_scaled   = (i_zero_count != 4'h0) && (top_window == '0); // see R11
    // Scaled form: top 16 bits under the leading zeros; shift clamps at 0.
    assign shift   = (i_top_bit >= 5'(15 + i_zero_count))
                   ? 5'(i_top_bit - 5'(15 + i_zero_count)) : 5'h00;
    assign aligned = masked >> shift;
    assign o_data  = o_scaled ? aligned[15:0] : masked[15:0]; // see R11
endmodule

// file: dv/lsm_meas_ctrl_checker.sv
// Purpose: Port-level assertions for the measurement control bank.
// Assumes: One clock; reset is asynchronous and active high.
// Notes:   Attached to the design by the bind below the module.
`include "lsm_map.svh"
module lsm_meas_ctrl_checker (
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire logic [7:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic        o_avs_waitrequest,
    input wire logic        i_flicker_done,
    input wire logic        i_analog_sat,
    input wire logic [3:0]  i_gain_step,
    input wire logic [2:0]  o_modulator_off,
    input wire logic        o_osc_run,
    input wire logic        o_flicker_run,
    input wire logic        o_ambient_run,
    input wire logic [1:0]  o_gain_drop,
    input wire logic        o_trailer_valid
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // A write only counts once answered and with the low lane enabled.
    logic       req, wr_ok, en_wr;
    logic [7:0] wd_lo, run_b;
    assign req   = i_avs_read || i_avs_write;
    assign wr_ok = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
    assign en_wr = wr_ok && i_avs_address == `LSM_IDX_ENABLE;
    assign wd_lo = i_avs_writedata[7:0];
    assign run_b = {1'b0, o_flicker_run, 4'h0, o_ambient_run, o_osc_run};

    chk_bus_answer: assert property (
        req && !$past(req) |=> !o_avs_waitrequest)
        else $error("bus answer late");
    chk_wait_pulse: assert property (
        !o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
    chk_mod_follow: assert property (
        wr_ok && i_avs_address == `LSM_IDX_MOD_OFF
        |=> {5'h00, o_modulator_off} == ($past(wd_lo) & 8'h07))
        else $error("modulator disables wrong");
    chk_power_up: assert property (
        en_wr && wd_lo[0] |=> run_b == ($past(wd_lo) & 8'h43))
        else $error("run outputs wrong after enable write");
    chk_power_down: assert property (
        en_wr && !wd_lo[0] |=> run_b == 8'h00)
        else $error("power off left something running");
    chk_run_needs_osc: assert property (
        o_flicker_run || o_ambient_run |-> o_osc_run)
        else $error("sensing without oscillator");
    chk_no_sat_drop: assert property (
        !i_analog_sat |=> o_gain_drop == 2'h0)
        else $error("gain drop without cause");
    chk_floor_single: assert property (
        i_analog_sat && i_gain_step == 4'h0 |=> o_gain_drop == 2'h1)
        else $error("gain step zero did not give a single drop");
    chk_sat_drops: assert property (
        i_analog_sat && i_gain_step != 4'h0
        |=> o_gain_drop != 2'h0 && o_gain_drop != 2'h3)
        else $error("saturation gave no gain drop");
    chk_trailer_cause: assert property (
        o_trailer_valid |-> $past(i_flicker_done) || $past(i_flicker_done, 2)
        || $past(i_flicker_done, 3) || $past(i_flicker_done, 4)
        || $past(i_flicker_done, 5))
        else $error("trailer item without measurement end");

    cov_power_off: cover property (en_wr && !wd_lo[0] && o_ambient_run);
    cov_double: cover property (o_gain_drop == 2'h2);
    cov_trailer: cover property (o_trailer_valid);
endmodule

bind lsm_meas_ctrl lsm_meas_ctrl_checker u_lsm_meas_ctrl_checker (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_waitrequest(o_avs_waitrequest), .i_flicker_done(i_flicker_done),
    .i_analog_sat(i_analog_sat), .i_gain_step(i_gain_step),
    .o_modulator_off(o_modulator_off), .o_osc_run(o_osc_run),
    .o_flicker_run(o_flicker_run), .o_ambient_run(o_ambient_run),
    .o_gain_drop(o_gain_drop), .o_trailer_valid(o_trailer_valid));

// file: dv/lsm_meas_ctrl_tb.sv
// Purpose: Self-checking bench for the measurement control bank.
// Assumes: The bus answers within a few cycles; engine events are pulses.
// Notes:   Bus read data is taken at the rising edge; other outputs are judged at the falling edge, once settled.
module lsm_meas_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import lsm_pkg::*;
    logic         clk, rst, rd_s, wr_s, wreq, mdone, fdone, sdone, sat;
    logic         endless, valid, scaled, osc, flk, amb, sleep, stq;
    logic [7:0]   adr;
    logic [31:0]  wd, rdata, amb_res;
    logic [3:0]   be, gstep;
    logic [2:0]   moff;
    logic [1:0]   drop;
    logic [15:0]  amb_data;
    lsm_trailer_e item;
    int           n_fail, n_compared;

    lsm_meas_ctrl u_lsm_meas_ctrl (
        .i_core_clk(clk), .i_rst(rst), .i_avs_address(adr),
        .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wd),
        .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .i_meas_done(mdone),
        .i_flicker_done(fdone), .i_seq_cycle_done(sdone),
        .i_analog_sat(sat), .i_gain_step(gstep),
        .i_flicker_endless_repeat(endless), .i_amb_result(amb_res),
        .o_modulator_off(moff), .o_osc_run(osc), .o_flicker_run(flk),
        .o_ambient_run(amb), .o_sleep_after_irq(sleep),
        .o_gain_drop(drop), .o_ambient_status_to_queue(stq),
        .o_trailer_valid(valid), .o_trailer_item(item),
        .o_amb_data(amb_data), .o_amb_scaled(scaled));

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s %h/%h", $time, what, got, exp);
        end
    endtask

    // The request is held until waitrequest is seen low, so no edge is lost.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        adr  <= a;
        wd   <= {24'hA5A5A5, d};
        rd_s <= !w;
        wr_s <= w;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0);
        q = rdata;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
        check(n, 32'h2, "bus answer");
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string what);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        check(q, e, what);
    endtask

    task automatic settle();
        repeat (2) @(negedge clk);
    endtask

    function automatic logic [31:0] runs();
        return {29'h0, osc, flk, amb};
    endfunction

    task automatic t_reset();
        rd(8'h40, 32'h00, "mod reset");
        rd(8'h80, 32'h00, "enable reset");
        rd(8'h81, 32'h04, "mode low reset");
        rd(8'h82, 32'h0C, "mode high reset");
        rd(8'h10, 32'h00, "unmapped");
    endtask

    task automatic t_mod();
        for (int i = 0; i < 3; i++) begin
            wr(8'h40, 8'hF8 | (8'h01 << i));
            settle();
            check({29'h0, moff}, 32'h1 << i, "modulator off");
            rd(8'h40, 32'h1 << i, "mod readback");
        end
        @(posedge clk) be <= 4'hE;
        wr(8'h40, 8'h00);
        @(posedge clk) be <= 4'hF;
        rd(8'h40, 32'h4, "lane off write");
    endtask

    task automatic t_enable();
        wr(8'h80, 8'hFF);
        settle();
        check(runs(), 32'h7, "all on");
        rd(8'h80, 32'h43, "enable readback");
        wr(8'h80, 8'h41);
        settle();
        check(runs(), 32'h6, "ambient off");
        wr(8'h80, 8'h03);
        settle();
        check(runs(), 32'h5, "flicker off");
        wr(8'h80, 8'h42);
        rd(8'h80, 32'h00, "power off clears");
    endtask

    task automatic t_stop();
        for (int s = 0; s < 2; s++) begin
            wr(8'h81, s ? 8'h84 : 8'h04);
            wr(8'h80, 8'h43);
            @(posedge clk) mdone <= 1'b1;
            @(posedge clk) mdone <= 1'b0;
            settle();
            check(runs(), s ? 32'h4 : 32'h7, "stop after count");
        end
        // A count of two lets the first run pass and stops on the second.
        wr(8'h92, 8'h02);
        wr(8'h80, 8'h43);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) mdone <= 1'b1;
            @(posedge clk) mdone <= 1'b0;
            settle();
            check(runs(), k ? 32'h4 : 32'h7, "nth stop");
        end
        wr(8'h80, 8'h00);
    endtask

    task automatic t_gain();
        @(posedge clk);
        sat   <= 1'b1;
        gstep <= 4'h5;
        for (int d = 0; d < 2; d++) begin
            wr(8'h81, d ? 8'h44 : 8'h04);
            settle();
            check({30'h0, drop}, d ? 32'h2 : 32'h1, "gain drop");
        end
        @(posedge clk) gstep <= 4'h0;
        settle();
        check({30'h0, drop}, 32'h1, "drop at floor");
        @(posedge clk) sat <= 1'b0;
    endtask

    task automatic t_sleep();
        for (int s = 0; s < 2; s++) begin
            wr(8'h81, s ? 8'h24 : 8'h04);
            wr(8'h80, 8'h01);
            @(posedge clk) sdone <= 1'b1;
            @(posedge clk) sdone <= 1'b0;
            settle();
            check({31'h0, sleep}, s, "single shot");
        end
        wr(8'h80, 8'h00);
        settle();
        check({31'h0, sleep}, 32'h0, "sleep cleared");
    endtask

    task automatic t_amb();
        @(posedge clk) amb_res <= 32'h0001_2345;
        wr(8'h81, 8'h10);
        settle();
        check({31'h0, stq}, 32'h1, "status on");
        check({scaled, amb_data}, 32'h0345, "no scaling");
        @(posedge clk) amb_res <= 32'h0000_1F00;
        wr(8'h81, 8'h04);
        settle();
        check({31'h0, stq}, 32'h0, "status off");
        check({scaled, amb_data}, 32'h1F00, "top bits set");
        @(posedge clk) amb_res <= 32'h0000_0005;
        settle();
        check({31'h0, scaled}, 32'h1, "scaled");
        // Top bit 31 with four leading zeros keeps bits 27 down to 12.
        wr(8'h82, 8'h1F);
        @(posedge clk) amb_res <= 32'h0012_3456;
        settle();
        check({scaled, amb_data}, 32'h10123, "scaled shift");
        rd(8'h91, 32'h10123, "result read");
    endtask

    // Each item seen is shifted in behind a leading one, keeping the order.
    task automatic t_trailer();
        logic [7:0] m [5] = '{8'h20, 8'h40, 8'h80, 8'hE0, 8'hE0};
        logic [7:0] got, exp;
        for (int k = 0; k < 5; k++) begin
            @(posedge clk) endless <= (k == 4);
            wr(8'h82, m[k] | 8'h0C);
            @(posedge clk) fdone <= 1'b1;
            @(posedge clk) fdone <= 1'b0;
            got = 8'h01;
            repeat (7) begin
                @(negedge clk);
                if (valid === 1'b1) got = {got[5:0], item};
            end
            exp = 8'h01;
            if (m[k][5]) exp = {exp[5:0], LSM_TRL_GAIN};
            if (m[k][6]) exp = {exp[5:0], LSM_TRL_CHECKSUM};
            if (m[k][7] && k != 4) exp = {exp[5:0], LSM_TRL_END};
            check(got, exp, "trailer");
        end
    endtask

    task automatic complete_run();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        $display("MISMATCH %0t watchdog", $time);
        complete_run();
    end

    initial begin
        {rst, rd_s, wr_s, mdone, fdone, sdone, sat, endless} = 8'h80;
        {adr, be, gstep, wd, amb_res} = {8'h00, 4'hF, 4'h0, 64'h0};
        n_fail = 0;
        n_compared = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_mod();
        t_enable();
        t_stop();
        t_gain();
        t_sleep();
        t_amb();
        t_trailer();
        complete_run();
    end
endmodule
